// >>> rtl/tas_alarm.sv
// status flags, alert latch, overheat pins and configuration of the monitor
`timescale 1ns/1ps
`include "tas_cfg.svh"

// Notes on behaviour
// - status register read-only at pointer 02h
// - bit 7 shows conversion in progress
// - bits 6..0 hold the seven trip flags
// - alert mode: five flags latch until read
// - secondary mode: only open flag is sticky
// - alert mode: any of the five latched flags sets latch, pin low
// - status read clears flags whose cause left
// - latch released only by address read
// - overheat flags set and clear by themselves
// - overheat pin releases at or below limit minus hysteresis
// - secondary pin follows high limits, hysteretic
// - config written 09h, read 03h, resets 00h
// - bit 7 masks alert pin, alert mode only
// - bit 6 shuts down after current sequence
// - clearing shutdown resumes; one-shot while shut
// - bit 5 picks alert or secondary pin
// - bit 2 selects standard or extended range
// - write to 0Fh runs one cycle, unstored
module tas_alarm (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_ptr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic addr_rd,
  input wire logic rate_tick,
  output logic conv_req,
  output logic conv_remote,
  input wire logic result_valid,
  input wire tas_pkg::tas_temp_t result_temp,
  input wire logic remote_open,
  input wire tas_pkg::tas_temp_t local_high_lim,
  input wire tas_pkg::tas_temp_t local_low_lim,
  input wire tas_pkg::tas_temp_t remote_high_lim,
  input wire tas_pkg::tas_temp_t remote_low_lim,
  input wire tas_pkg::tas_temp_t local_overheat_output_lim,
  input wire tas_pkg::tas_temp_t remote_overheat_output_lim,
  input wire tas_pkg::tas_temp_t overheat_output_hyst,
  output logic range_extended,
  output logic overheat_output_o,
  output logic overheat_output_oe,
  output logic mpin_o,
  output logic mpin_oe
);
  import tas_pkg::*;

  // ==========================================================
  // state
  tas_seq_t seq_q, seq_d;
  logic oneshot_q, oneshot_d;
  logic [7:0] cfg_q, cfg_d;
  logic [4:0] cond_q, cond_d;
  logic [4:0] flag_q, flag_d;
  logic lth_q, lth_d;
  logic rth_q, rth_d;
  logic lh2_q, lh2_d;
  logic rh2_q, rh2_d;
  logic alert_q, alert_d;
  logic [7:0] rdata_q, rdata_d;
  logic overheat_output_low_q, overheat_output_low_d;
  logic mpin_low_q, mpin_low_d;

  // ==========================================================
  // decoded accesses and configuration fields
  logic st_rd;
  logic cfg_wr;
  logic os_wr;
  logic alert_mask;
  logic shutdown_bit;
  logic pin_function_select;
  logic loc_done;
  logic rem_done;
  logic [7:0] status;

  assign st_rd = reg_rd && (reg_ptr == `TAS_PTR_STATUS);
  assign cfg_wr = reg_wr && (reg_ptr == `TAS_PTR_CFG_WR);
  assign os_wr = reg_wr && (reg_ptr == `TAS_PTR_ONESHOT);
  assign alert_mask = cfg_q[`TAS_CFG_MASK];
  assign shutdown_bit = cfg_q[`TAS_CFG_SD];
  assign pin_function_select = cfg_q[`TAS_CFG_FSEL];
  assign range_extended = cfg_q[`TAS_CFG_RANGE];
  assign loc_done = result_valid && (seq_q == TAS_CONV_LOCAL);
  assign rem_done = result_valid && (seq_q == TAS_CONV_REMOTE);

  // ==========================================================
  // conversion sequencer
  always_comb begin
    seq_d = seq_q;
    oneshot_d = oneshot_q;
    unique case (seq_q)
      TAS_IDLE: begin
        // running converts on rate ticks, shutdown only on a one-shot
        if ((!shutdown_bit && rate_tick) || oneshot_q) begin
          seq_d = TAS_CONV_LOCAL;
          oneshot_d = 1'b0;
        end
      end
      TAS_CONV_LOCAL: begin
        if (result_valid) begin
          seq_d = TAS_CONV_REMOTE;
        end
      end
      TAS_CONV_REMOTE: begin
        // sequence always completes before shutdown takes hold
        if (result_valid) begin
          seq_d = TAS_IDLE;
        end
      end
      // unused code falls back to idle
      default: begin
        seq_d = TAS_IDLE;
      end
    endcase
    // one-shot only counts while shut down; data is discarded
    if (os_wr && shutdown_bit) begin
      oneshot_d = 1'b1;
    end
    if (!shutdown_bit) begin
      oneshot_d = 1'b0;
    end
  end

  assign conv_req = (seq_q != TAS_IDLE);
  assign conv_remote = (seq_q == TAS_CONV_REMOTE);

  // ==========================================================
  // configuration register, reserved bits kept at zero
  always_comb begin
    cfg_d = cfg_q;
    if (cfg_wr) begin
      cfg_d = reg_wdata & `TAS_CFG_WMASK;
    end
  end

  // ==========================================================
  // limit comparison on each finished channel
  always_comb begin
    cond_d = cond_q;
    lth_d = lth_q;
    rth_d = rth_q;
    lh2_d = lh2_q;
    rh2_d = rh2_q;
    if (loc_done) begin
      cond_d[`TAS_FL_LH] = result_temp > local_high_lim;
      cond_d[`TAS_FL_LL] = result_temp < local_low_lim;
      // sum compare keeps limit minus hysteresis from wrapping
      if (result_temp > local_overheat_output_lim) begin
        lth_d = 1'b1;
      end else if ({1'b0, result_temp} + {1'b0, overheat_output_hyst} <=
                   {1'b0, local_overheat_output_lim}) begin
        lth_d = 1'b0;
      end
      if (result_temp > local_high_lim) begin
        lh2_d = 1'b1;
      end else if ({1'b0, result_temp} + {1'b0, overheat_output_hyst} <=
                   {1'b0, local_high_lim}) begin
        lh2_d = 1'b0;
      end
    end
    if (rem_done) begin
      cond_d[`TAS_FL_RH] = result_temp > remote_high_lim;
      cond_d[`TAS_FL_RL] = result_temp < remote_low_lim;
      cond_d[`TAS_FL_OP] = remote_open;
      if (result_temp > remote_overheat_output_lim) begin
        rth_d = 1'b1;
      end else if ({1'b0, result_temp} + {1'b0, overheat_output_hyst} <=
                   {1'b0, remote_overheat_output_lim}) begin
        rth_d = 1'b0;
      end
      if (result_temp > remote_high_lim) begin
        rh2_d = 1'b1;
      end else if ({1'b0, result_temp} + {1'b0, overheat_output_hyst} <=
                   {1'b0, remote_high_lim}) begin
        rh2_d = 1'b0;
      end
    end
  end

  // ==========================================================
  // sticky flags: a new trip in the read cycle wins over the clear
  always_comb begin
    logic [4:0] trip;
    logic [4:0] sticky;
    trip = '0;
    // secondary mode keeps only the open flag sticky
    sticky = pin_function_select ? `TAS_FL_STK_SEC
                                 : `TAS_FL_STK_ALR;
    trip[`TAS_FL_LH] = loc_done && cond_d[`TAS_FL_LH];
    trip[`TAS_FL_LL] = loc_done && cond_d[`TAS_FL_LL];
    trip[`TAS_FL_RH] = rem_done && cond_d[`TAS_FL_RH];
    trip[`TAS_FL_RL] = rem_done && cond_d[`TAS_FL_RL];
    trip[`TAS_FL_OP] = rem_done && cond_d[`TAS_FL_OP];
    flag_d = flag_q;
    if (st_rd) begin
      flag_d = flag_q & cond_q;
    end
    flag_d = (flag_d | trip) & sticky;
  end

  // ==========================================================
  // alert latch, released only by the address read
  always_comb begin
    alert_d = alert_q;
    if (addr_rd && (flag_q == `TAS_FL_RESET) &&
        (cond_q == `TAS_FL_RESET)) begin
      alert_d = 1'b0;
    end
    if (!pin_function_select && (flag_q != `TAS_FL_RESET)) begin
      alert_d = 1'b1;
    end
  end

  // ==========================================================
  // status view and pin levels
  always_comb begin
    status = '0;
    status[`TAS_ST_BUSY] = conv_req;
    if (pin_function_select) begin
      status[`TAS_ST_LOCAL_HIGH_TRIP_FLAG] = lh2_q;
      status[`TAS_ST_LOCAL_LOW_TRIP_FLAG] = cond_q[`TAS_FL_LL];
      status[`TAS_ST_REMOTE_HIGH_TRIP_FLAG] = rh2_q;
      status[`TAS_ST_REMOTE_LOW_TRIP_FLAG] = cond_q[`TAS_FL_RL];
    end else begin
      status[`TAS_ST_LOCAL_HIGH_TRIP_FLAG] = flag_q[`TAS_FL_LH];
      status[`TAS_ST_LOCAL_LOW_TRIP_FLAG] = flag_q[`TAS_FL_LL];
      status[`TAS_ST_REMOTE_HIGH_TRIP_FLAG] = flag_q[`TAS_FL_RH];
      status[`TAS_ST_REMOTE_LOW_TRIP_FLAG] = flag_q[`TAS_FL_RL];
    end
    status[`TAS_ST_OPEN] = flag_q[`TAS_FL_OP];
    status[`TAS_ST_RTH] = rth_q;
    status[`TAS_ST_LTH] = lth_q;
    overheat_output_low_d = lth_d || rth_d;
    // low limits never reach the secondary pin
    if (pin_function_select) begin
      mpin_low_d = lh2_d || rh2_d;
    end else begin
      mpin_low_d = alert_d && !alert_mask;
    end
  end

  // ==========================================================
  // read data, captured on the read strobe
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      unique case (reg_ptr)
        `TAS_PTR_STATUS: rdata_d = status;
        `TAS_PTR_CFG_RD: rdata_d = cfg_q;
        default: rdata_d = `TAS_RD_RESET;
      endcase
    end
  end

  // ==========================================================
  // registers, frozen while ce is low
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seq_q <= TAS_IDLE;
      oneshot_q <= 1'b0;
      cfg_q <= `TAS_CFG_RESET;
      cond_q <= `TAS_FL_RESET;
      flag_q <= `TAS_FL_RESET;
      lth_q <= 1'b0;
      rth_q <= 1'b0;
      lh2_q <= 1'b0;
      rh2_q <= 1'b0;
      alert_q <= 1'b0;
      rdata_q <= `TAS_RD_RESET;
      overheat_output_low_q <= 1'b0;
      mpin_low_q <= 1'b0;
    end else if (ce) begin
      seq_q <= seq_d;
      oneshot_q <= oneshot_d;
      cfg_q <= cfg_d;
      cond_q <= cond_d;
      flag_q <= flag_d;
      lth_q <= lth_d;
      rth_q <= rth_d;
      lh2_q <= lh2_d;
      rh2_q <= rh2_d;
      alert_q <= alert_d;
      rdata_q <= rdata_d;
      overheat_output_low_q <= overheat_output_low_d;
      mpin_low_q <= mpin_low_d;
    end
  end

  // ==========================================================
  // open-drain pins only ever pull low
  assign reg_rdata = rdata_q;
  assign overheat_output_o = 1'b0;
  assign overheat_output_oe = overheat_output_low_q;
  assign mpin_o = 1'b0;
  assign mpin_oe = mpin_low_q;
endmodule : tas_alarm

// >>> inc/tas_cfg.svh
// register addresses, field positions and reset values of the alarm block
`ifndef TAS_CFG_SVH
`define TAS_CFG_SVH
// ==========================================================
// pointer addresses
`define TAS_PTR_STATUS 8'h02
`define TAS_PTR_CFG_RD 8'h03
`define TAS_PTR_CFG_WR 8'h09
`define TAS_PTR_ONESHOT 8'h0F
// ==========================================================
// configuration fields
`define TAS_CFG_MASK 7
`define TAS_CFG_SD 6
`define TAS_CFG_FSEL 5
`define TAS_CFG_RANGE 2
`define TAS_CFG_WMASK 8'hE4
`define TAS_CFG_RESET 8'h00
// ==========================================================
// status fields
`define TAS_ST_BUSY 7
`define TAS_ST_LOCAL_HIGH_TRIP_FLAG 6
`define TAS_ST_LOCAL_LOW_TRIP_FLAG 5
`define TAS_ST_REMOTE_HIGH_TRIP_FLAG 4
`define TAS_ST_REMOTE_LOW_TRIP_FLAG 3
`define TAS_ST_OPEN 2
`define TAS_ST_RTH 1
`define TAS_ST_LTH 0
// ==========================================================
// latched flag vector positions
`define TAS_FL_LH 4
`define TAS_FL_LL 3
`define TAS_FL_RH 2
`define TAS_FL_RL 1
`define TAS_FL_OP 0
`define TAS_FL_RESET 5'h00
// sticky masks: all five in alert mode, open flag only in secondary mode
`define TAS_FL_STK_ALR 5'h1F
`define TAS_FL_STK_SEC 5'h01
`define TAS_RD_RESET 8'h00
`endif

// >>> inc/tas_pkg.sv
// types shared by the temperature alarm block
package tas_pkg;
  // temperature code as delivered by the converter
  typedef logic [11:0] tas_temp_t;
  // conversion sequencer states
  typedef enum logic [1:0] {
    TAS_IDLE,
    TAS_CONV_LOCAL,
    TAS_CONV_REMOTE
  } tas_seq_t;
endpackage : tas_pkg

// >>> bench/tas_alarm_checker.sv
// port-level assertions for the alarm block
`timescale 1ns/1ps
module tas_alarm_checker (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_ptr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic addr_rd,
  input wire logic conv_req,
  input wire logic conv_remote,
  input wire logic result_valid,
  input wire logic range_extended,
  input wire logic mpin_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // register port
  AST_BUSY_BIT: assert property (
    reg_rd && ce && reg_ptr == 8'h02 |=> reg_rdata[7] == $past(conv_req))
    else $error("busy bit wrong");
  AST_CFG_BACK: assert property (
    reg_wr && ce && reg_ptr == 8'h09 ##2 reg_rd && ce && reg_ptr == 8'h03
    && !$past(reg_wr) |=> reg_rdata == ($past(reg_wdata, 3) & 8'hE4))
    else $error("config readback wrong");
  AST_RANGE: assert property (
    reg_wr && ce && reg_ptr == 8'h09 |=> range_extended == $past(reg_wdata[2]))
    else $error("range bit wrong");
  AST_RDATA_HOLD: assert property (
    !(reg_rd && ce) |=> $stable(reg_rdata)) else $error("read data moved");
  // ==========================================================
  // conversion sequence
  AST_LOCAL_FIRST: assert property (
    $rose(conv_req) |-> !conv_remote) else $error("remote first");
  AST_TO_REMOTE: assert property (
    conv_req && !conv_remote && result_valid && ce |=> conv_req && conv_remote)
    else $error("no remote step");
  AST_SEQ_DONE: assert property (
    conv_req && conv_remote && result_valid && ce |=> !conv_req)
    else $error("busy stuck");
  // alert pin release needs an address read, a write or a new result
  AST_ALERT_HELD: assert property (
    $fell(mpin_oe) |-> $past(addr_rd) || $past(reg_wr) || $past(reg_wr, 2)
    || $past(result_valid) || $past(result_valid, 2)
    || $past(result_valid, 3)) else $error("pin released early");
  COV_SEQ: cover property (conv_req && conv_remote && result_valid);
  COV_PIN_SET: cover property ($rose(mpin_oe));
  COV_PIN_REL: cover property ($fell(mpin_oe));
endmodule : tas_alarm_checker

bind tas_alarm tas_alarm_checker u_chk (.*);

// >>> bench/tas_conv_model.sv
// converter stand-in answering conversion requests
`timescale 1ns/1ps
module tas_conv_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic conv_req,
  input wire logic conv_remote,
  input wire logic [3:0] lat,
  input wire tas_pkg::tas_temp_t local_t,
  input wire tas_pkg::tas_temp_t remote_t,
  input wire logic open_i,
  output logic result_valid,
  output tas_pkg::tas_temp_t result_temp,
  output logic remote_open
);
  import tas_pkg::*;
  logic [3:0] cnt;
  // wait lat cycles, give one result; idle lines keep toggling
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      result_valid <= 1'b0;
      result_temp <= 12'h000;
      remote_open <= 1'b0;
    end else if (conv_req && !result_valid && cnt == lat) begin
      cnt <= 4'h0;
      result_valid <= 1'b1;
      result_temp <= conv_remote ? remote_t : local_t;
      remote_open <= conv_remote & open_i;
    end else begin
      cnt <= (conv_req && !result_valid) ? cnt + 4'h1 : 4'h0;
      result_valid <= 1'b0;
      result_temp <= ~result_temp;
      remote_open <= ~remote_open;
    end
  end
endmodule : tas_conv_model

// >>> bench/tas_alarm_test.sv
// self-checking bench for the alarm and configuration block
`timescale 1ns/1ps
module tas_alarm_test;
  import tas_pkg::*;
  logic clock = 0, rst_n = 0, ce = 1, reg_wr = 0, reg_rd = 0, addr_rd = 0;
  logic rate_tick = 0, rd_pend = 0, op = 0, ooe, moe, rv, ro, rx, cq, cr;
  logic oo, mo;
  logic [7:0] reg_ptr = 0, reg_wdata = 0, reg_rdata;
  logic [3:0] lat = 4'h8;
  logic [31:0] rs = 32'h12DA;
  tas_temp_t lt = 12'h300, rt = 12'h300, rtemp, hl = 12'h550, ll = 12'h100;
  tas_temp_t th = 12'h6E0, hy = 12'h0A0;
  int n_mismatch = 0, cmp_count = 0;
  logic [7:0] expq[$];
  always #2.5 clock = ~clock;
  tas_alarm u_dut (.clock(clock), .rst_n(rst_n), .ce(ce), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_ptr(reg_ptr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .addr_rd(addr_rd), .rate_tick(rate_tick),
    .conv_req(cq), .conv_remote(cr), .result_valid(rv), .result_temp(rtemp),
    .remote_open(ro), .local_high_lim(hl), .local_low_lim(ll),
    .remote_high_lim(hl), .remote_low_lim(ll), .local_overheat_output_lim(th),
    .remote_overheat_output_lim(th), .overheat_output_hyst(hy), .range_extended(rx),
    .overheat_output_o(oo), .overheat_output_oe(ooe), .mpin_o(mo),
    .mpin_oe(moe));
  tas_conv_model u_conv (.clock(clock), .rst_n(rst_n), .conv_req(cq),
    .conv_remote(cr), .lat(lat), .local_t(lt), .remote_t(rt), .open_i(op),
    .result_valid(rv), .result_temp(rtemp), .remote_open(ro));
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  task automatic chk(input string nm, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic complete_run;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  // one-cycle strobe, k = {addr_rd, rate_tick, reg_rd, reg_wr}
  task automatic pulse(input logic [3:0] k, input logic [7:0] p, d);
    @(posedge clock);
    #1 {addr_rd, rate_tick, reg_rd, reg_wr} = k;
    reg_ptr = p;
    reg_wdata = d;
    @(posedge clock);
    #1 {addr_rd, rate_tick, reg_rd, reg_wr} = 4'h0;
  endtask : pulse
  task automatic rd(input logic [7:0] p, e);
    expq.push_back(e);
    pulse(4'h2, p, 8'h00);
  endtask : rd
  // wait for a sequence to start and end, bounded
  task automatic fin;
    int i;
    logic seen;
    seen = 0;
    for (i = 0; i < 80 && !(seen && !cq); i++) begin
      @(posedge clock);
      seen |= cq;
    end
    if (i == 80) chk("sequence", 8'h01, 8'h00);
    repeat (3) @(posedge clock);
    #1;
  endtask : fin
  task automatic run(input tas_temp_t l, r, input logic o, s);
    lt = l;
    rt = r;
    op = o;
    rs = nx(rs);
    lat = {2'b00, rs[1:0]} + 4'h2;
    pulse(s ? 4'h1 : 4'h4, s ? 8'h0F : 8'h00, rs[15:8]);
    fin();
  endtask : run
  // compare each read result with the oldest expectation
  always @(posedge clock) begin
    if (rd_pend) chk("reg_rdata", expq.pop_front(), reg_rdata);
    rd_pend <= reg_rd && ce;
  end
  initial begin
    #100000 n_mismatch++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge clock);
    #1 rst_n = 1;
    rd(8'h03, 8'h00);
    rs = nx(rs);
    pulse(4'h1, 8'h09, rs[7:0] & 8'hE4);
    rd(8'h03, rs[7:0] & 8'hE4);
    chk("range_extended", {7'h0, rs[2]}, {7'h0, rx});
    pulse(4'h1, 8'h02, 8'hFF);
    rd(8'h03, rs[7:0] & 8'hE4);
    pulse(4'h1, 8'h09, 8'h00);
    pulse(4'h4, 8'h00, 8'h00);
    repeat (3) @(posedge clock);
    rd(8'h02, 8'h80);
    fin();
    run(12'h600, 12'h080, 0, 0);
    chk("mpin_oe", 8'h01, {7'h0, moe});
    pulse(4'h8, 8'h00, 8'h00);
    repeat (3) @(posedge clock);
    #1;
    chk("mpin_oe", 8'h01, {7'h0, moe});
    run(12'h300, 12'h300, 0, 0);
    rd(8'h02, 8'h48);
    rd(8'h02, 8'h00);
    chk("mpin_oe", 8'h01, {7'h0, moe});
    pulse(4'h8, 8'h00, 8'h00);
    repeat (3) @(posedge clock);
    #1;
    chk("mpin_oe", 8'h00, {7'h0, moe});
    run(12'h300, 12'h700, 0, 0);
    chk("overheat_oe", 8'h01, {7'h0, ooe});
    rd(8'h02, 8'h12);
    run(12'h300, 12'h6D0, 0, 0);
    chk("overheat_oe", 8'h01, {7'h0, ooe});
    run(12'h300, 12'h640, 0, 0);
    chk("overheat_oe", 8'h00, {7'h0, ooe});
    rd(8'h02, 8'h10);
    run(12'h300, 12'h300, 0, 0);
    rd(8'h02, 8'h10);
    pulse(4'h8, 8'h00, 8'h00);
    pulse(4'h1, 8'h09, 8'h20);
    run(12'h600, 12'h300, 0, 0);
    chk("mpin_oe", 8'h01, {7'h0, moe});
    run(12'h4C0, 12'h300, 0, 0);
    chk("mpin_oe", 8'h01, {7'h0, moe});
    run(12'h300, 12'h080, 0, 0);
    chk("mpin_oe", 8'h00, {7'h0, moe});
    rd(8'h02, 8'h08);
    run(12'h300, 12'h300, 1, 0);
    run(12'h300, 12'h300, 0, 0);
    rd(8'h02, 8'h04);
    rd(8'h02, 8'h00);
    pulse(4'h1, 8'h09, 8'h80);
    run(12'h600, 12'h300, 0, 0);
    chk("mpin_oe", 8'h00, {7'h0, moe});
    pulse(4'h1, 8'h09, 8'h40);
    pulse(4'h4, 8'h00, 8'h00);
    repeat (4) @(posedge clock);
    #1;
    chk("conv_req", 8'h00, {7'h0, cq});
    run(12'h300, 12'h300, 0, 1);
    rd(8'h03, 8'h40);
    pulse(4'h1, 8'h09, 8'h00);
    run(12'h300, 12'h300, 0, 0);
    // a write while the clock enable is low must not land
    ce = 0;
    pulse(4'h1, 8'h09, 8'hE4);
    ce = 1;
    rd(8'h03, 8'h00);
    // open-drain data lines only ever carry a low level
    chk("pin_data", 8'h00, {6'h0, oo, mo});
    complete_run();
  end
endmodule : tas_alarm_test
